// >>> core/msa_pkg.sv
package msa_pkg;

   // Conversion clock derived from the system clock
   localparam int SYS_CLK_HZ       = 50_000_000;
   localparam int CONV_CLK_HZ      = 45_000;
   localparam int CONV_DIV         = SYS_CLK_HZ / CONV_CLK_HZ;
   localparam int TEMP_CONV_TICKS  = 96;
   localparam int VOLT_CONV_TICKS  = 68;
   localparam int CYCLE_WAIT_MS    = 1000;
   localparam int CYCLE_WAIT_TICKS = CYCLE_WAIT_MS * (CONV_CLK_HZ / 1000);

   // Register locations and bit positions
   localparam logic [7:0] START_REG_ADDR     = 8'h40;
   localparam logic [7:0] SFR_ADDR           = 8'h7c;
   localparam logic [7:0] CFG_ADDR           = 8'h7f;
   localparam int         START_BIT          = 0;
   localparam int         CFG_SOFT_RESET_BIT = 7;

   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [2:0] AVG_RESET       = 3'h2;
   localparam logic [6:0] CFG_RESET       = 7'h00;
   localparam logic [7:0] FAULT_READING   = 8'h80;

   // Averaging counts as log2 of measurements per reading
   localparam logic [2:0] AVG_SH_32     = 3'h5;
   localparam logic [2:0] AVG_SH_16     = 3'h4;
   localparam logic [2:0] AVG_SH_128    = 3'h7;
   localparam logic [2:0] AVG_SH_8      = 3'h3;
   localparam logic [2:0] AVG_SH_1      = 3'h0;

   localparam logic [2:0] CH_REMOTE1 = 3'h0;
   localparam logic [2:0] CH_AMBIENT = 3'h1;
   localparam logic [2:0] CH_REMOTE2 = 3'h7;

   typedef logic [7:0] msa_byte_type;

   typedef struct packed {
      logic [2:0] averaging_select;
      logic [1:0] spare;
      logic       global_alert_enable;
      logic       cycle_mode;
      logic       low_power_sel;
   } msa_sfr_type;

   localparam msa_sfr_type SFR_RESET = '{AVG_RESET, 2'h0, 1'b0, 1'b0, 1'b0};

   typedef struct packed {
      logic scl;
      logic sda;
   } msa_smb_type;

   typedef struct packed {
      logic       start;
      logic [2:0] channel;
   } msa_conv_type;

endpackage : msa_pkg

// >>> core/msa_ara_responder.sv
`timescale 1ns/1ps
`default_nettype none

module msa_ara_responder
   import msa_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire msa_smb_type smb,
   input  wire logic        armed,
   input  wire logic [6:0]  own_addr,
   output var  logic        sda_oe,
   output var  logic        ara_ack
);

   typedef enum logic [2:0] {ARA_IDLE, ARA_ADDR, ARA_ACK, ARA_DATA, ARA_WAIT} msa_ara_st_type;

   typedef struct packed {
      msa_ara_st_type st;
      logic           scl_prev;
      logic           sda_prev;
      logic [7:0]     shreg;
      logic [2:0]     bitcnt;
      logic           oe;
      logic           ack;
   } msa_ara_state_type;

   msa_ara_state_type q;
   msa_ara_state_type d;
   logic              rise;
   logic              fall;
   logic              start_c;
   logic              stop_c;
   logic [7:0]        byte_in;

   always_comb begin
      rise    = smb.scl & ~q.scl_prev;
      fall    = ~smb.scl & q.scl_prev;
      start_c = smb.scl & q.scl_prev & q.sda_prev & ~smb.sda;
      stop_c  = smb.scl & q.scl_prev & ~q.sda_prev & smb.sda;
      byte_in = {q.shreg[6:0], smb.sda};
      d          = q;
      d.ack      = 1'b0;
      d.scl_prev = smb.scl;
      d.sda_prev = smb.sda;
      // A start anywhere restarts the frame; a bare stop idles
      if (start_c) begin
         d.st     = ARA_ADDR;
         d.bitcnt = 3'h0;
         d.oe     = 1'b0;
      end else if (stop_c) begin
         d.st = ARA_IDLE;
         d.oe = 1'b0;
      end else begin
         case (q.st)
            ARA_ADDR: begin
               if (rise) begin
                  d.shreg  = byte_in;
                  d.bitcnt = q.bitcnt + 3'h1;
                  if (q.bitcnt == 3'h7) begin
                     if (byte_in == {ALERT_RESP_ADDR, 1'b1} && armed) begin
                        d.st = ARA_ACK;
                     end else begin
                        d.st = ARA_WAIT;
                     end
                  end
               end
            end
            ARA_ACK: begin
               if (fall && !q.oe) begin
                  d.oe = 1'b1;
               end else if (rise) begin
                  d.ack = 1'b1;
               end else if (fall) begin
                  d.shreg  = {own_addr, 1'b0};
                  d.oe     = ~own_addr[6];
                  d.bitcnt = 3'h0;
                  d.st     = ARA_DATA;
               end
            end
            ARA_DATA: begin
               if (fall) begin
                  d.bitcnt = q.bitcnt + 3'h1;
                  d.shreg  = {q.shreg[6:0], 1'b0};
                  if (q.bitcnt == 3'h7) begin
                     d.oe = 1'b0;
                     d.st = ARA_WAIT;
                  end else begin
                     d.oe = ~q.shreg[6];
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (!rstn) begin
         d.st       = ARA_IDLE;
         d.scl_prev = 1'b1;
         d.sda_prev = 1'b1;
         d.shreg    = 8'h00;
         d.bitcnt   = 3'h0;
         d.oe       = 1'b0;
         d.ack      = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ce || !rstn) begin
         q <= d;
      end
   end

   assign sda_oe  = q.oe;
   assign ara_ack = q.ack;

endmodule : msa_ara_responder

`default_nettype wire

// >>> core/msa_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module msa_monitor
   import msa_pkg::*;
#(
   parameter int CONV_DIV_P    = CONV_DIV,
   parameter int CYCLE_WAIT_P  = CYCLE_WAIT_TICKS
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   rstn,
   input  wire logic                   ce,
   input  wire logic                   start_write,
   input  wire logic [7:0]             start_wdata,
   input  wire logic                   sfr_write,
   input  wire msa_sfr_type            sfr_wdata,
   input  wire logic                   cfg_write,
   input  wire logic [7:0]             cfg_wdata,
   input  wire logic                   status_read,
   input  wire logic [7:0]             event_enable,
   input  wire logic                   temp_group_en,
   input  wire logic                   volt_group_en,
   input  wire msa_byte_type [7:0]     low_limit,
   input  wire msa_byte_type [7:0]     high_limit,
   input  wire logic [6:0]             slave_addr,
   input  wire logic [7:0]             conv_data,
   input  wire logic [1:0]             diode_fault,
   input  wire logic                   scl_pin,
   input  wire logic                   sda_pin,
   output var  logic                   sda_out,
   output var  logic                   sda_oe,
   output var  logic                   alert_n,
   output var  msa_conv_type           conv_req,
   output var  msa_byte_type [7:0]     reading,
   output var  logic [7:0]             status_bits,
   output var  logic [1:0]             fault_bits,
   output var  msa_sfr_type            special_function_register,
   output var  logic [7:0]             configuration_register,
   output var  logic                   monitor_running
);

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_WAIT} msa_seq_st_type;

   typedef struct packed {
      msa_smb_type        smb_m;
      msa_smb_type        smb_s;
      msa_sfr_type        sfr;
      logic [6:0]         cfg;
      logic               start;
      msa_seq_st_type     st;
      logic [2:0]         ch;
      logic [10:0]        div;
      logic               tick;
      logic [6:0]         len;
      logic [7:0]         meas;
      logic [14:0]        acc;
      logic [15:0]        wait_cnt;
      msa_conv_type       conv;
      logic [7:0]         stat;
      logic [7:0]         cond;
      logic [1:0]         fault;
      logic [1:0]         fault_cond;
      logic               alert_n;
      logic               sda_out;
      msa_byte_type [7:0] rd;
   } msa_mon_state_type;

   msa_mon_state_type q;
   msa_mon_state_type d;
   logic              ara_armed;
   logic              ara_ack;
   logic              soft_rst;
   logic [7:0]        grp_mask;
   logic              pending;

   function automatic logic [2:0] avg_shift(input logic [2:0] sel, input logic remote);
      logic [2:0] sh;
      sh = AVG_SH_1;
      if (sel[2]) begin
         sh = AVG_SH_32;
      end else if (sel[1]) begin
         sh = AVG_SH_16;
      end else if (sel[0]) begin
         sh = remote ? AVG_SH_16 : AVG_SH_1;
      end else begin
         sh = remote ? AVG_SH_128 : AVG_SH_8;
      end
      return sh;
   endfunction : avg_shift

   function automatic logic is_temp(input logic [2:0] ch);
      return (ch == CH_REMOTE1) || (ch == CH_AMBIENT) || (ch == CH_REMOTE2);
   endfunction : is_temp

   // Temperatures are two's complement; flip sign bit to order them
   function automatic logic [7:0] cmp_key(input logic [7:0] v, input logic temp);
      return temp ? {~v[7], v[6:0]} : v;
   endfunction : cmp_key

   assign grp_mask = {temp_group_en, {5{volt_group_en}}, temp_group_en, temp_group_en};
   assign pending  = |(q.stat & grp_mask);
   assign ara_armed = q.sfr.global_alert_enable & pending;
   assign soft_rst  = cfg_write & cfg_wdata[CFG_SOFT_RESET_BIT];

   msa_ara_responder u_ara (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .ce       (ce),
      .smb      (q.smb_s),
      .armed    (ara_armed),
      .own_addr (slave_addr),
      .sda_oe   (sda_oe),
      .ara_ack  (ara_ack)
   );

   always_comb begin
      logic [2:0]  sh;
      logic        temp;
      logic        remote;
      logic        flt;
      logic [14:0] acc_n;
      logic [7:0]  value;
      logic        viol;
      logic [7:0]  set_stat;
      logic [1:0]  set_fault;
      logic [6:0]  len_last;
      logic [7:0]  meas_last;
      sh        = 3'h0;
      temp      = is_temp(q.ch);
      remote    = (q.ch == CH_REMOTE1) || (q.ch == CH_REMOTE2);
      flt       = 1'b0;
      acc_n     = q.acc + {7'h00, conv_data};
      value     = 8'h00;
      viol      = 1'b0;
      set_stat  = 8'h00;
      set_fault = 2'h0;
      len_last  = temp ? 7'(TEMP_CONV_TICKS - 1) : 7'(VOLT_CONV_TICKS - 1);
      sh        = avg_shift(q.sfr.averaging_select, remote);
      meas_last = 8'((9'h001 << sh) - 9'h001);

      d            = q;
      d.smb_m      = '{scl: scl_pin, sda: sda_pin};
      d.smb_s      = q.smb_m;
      d.conv.start = 1'b0;
      d.sda_out    = 1'b0;

      if (start_write) begin
         d.start = start_wdata[START_BIT];
      end
      if (sfr_write) begin
         d.sfr = sfr_wdata;
      end
      if (cfg_write) begin
         d.cfg = cfg_wdata[6:0];
      end
      if (ara_ack) begin
         d.sfr.global_alert_enable = 1'b0;
      end

      d.tick = 1'b0;
      if (q.div == 11'(CONV_DIV_P - 1)) begin
         d.div  = 11'h000;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 11'h001;
      end

      case (q.st)
         SEQ_IDLE: begin
            if (q.start) begin
               d.st   = SEQ_CONV;
               d.ch   = CH_REMOTE1;
               d.len  = 7'h00;
               d.meas = 8'h00;
               d.acc  = 15'h0000;
               d.conv = '{start: 1'b1, channel: CH_REMOTE1};
            end
         end
         SEQ_CONV: begin
            if (!q.start) begin
               d.st = SEQ_IDLE;
            end else if (q.tick) begin
               if (q.len != len_last) begin
                  d.len = q.len + 7'h01;
               end else begin
                  d.len = 7'h00;
                  if (q.meas != meas_last) begin
                     d.meas = q.meas + 8'h01;
                     d.acc  = acc_n;
                     d.conv = '{start: 1'b1, channel: q.ch};
                  end else begin
                     flt = remote && diode_fault[q.ch == CH_REMOTE2];
                     value = flt ? FAULT_READING : 8'(acc_n >> sh);
                     d.rd[q.ch] = value;
                     viol = (cmp_key(value, temp) <= cmp_key(low_limit[q.ch], temp))
                         || (cmp_key(value, temp) >= cmp_key(high_limit[q.ch], temp));
                     d.cond[q.ch] = viol;
                     set_stat[q.ch] = viol & event_enable[q.ch];
                     if (remote) begin
                        d.fault_cond[q.ch == CH_REMOTE2] = flt;
                        set_fault[q.ch == CH_REMOTE2]    = flt;
                     end
                     d.meas = 8'h00;
                     d.acc  = 15'h0000;
                     d.ch   = q.ch + 3'h1;
                     if (q.ch == CH_REMOTE2 && q.sfr.cycle_mode) begin
                        d.st       = SEQ_WAIT;
                        d.wait_cnt = 16'h0000;
                     end else begin
                        d.conv = '{start: 1'b1, channel: q.ch + 3'h1};
                     end
                  end
               end
            end
         end
         SEQ_WAIT: begin
            if (!q.start) begin
               d.st = SEQ_IDLE;
            end else if (q.tick) begin
               if (q.wait_cnt == 16'(CYCLE_WAIT_P - 1)) begin
                  d.st   = SEQ_CONV;
                  d.len  = 7'h00;
                  d.conv = '{start: 1'b1, channel: CH_REMOTE1};
               end else begin
                  d.wait_cnt = q.wait_cnt + 16'h0001;
               end
            end
         end
         default: begin
            d.st = SEQ_IDLE;
         end
      endcase

      // read clears only vanished conditions; set wins
      d.stat  = (q.stat & (status_read ? q.cond : 8'hff)) | set_stat;
      d.fault = (q.fault & (status_read ? q.fault_cond : 2'h3)) | set_fault;

      d.alert_n = ~(q.start & q.sfr.global_alert_enable & pending);

      if (!rstn || soft_rst) begin
         d.sfr        = SFR_RESET;
         d.cfg        = CFG_RESET;
         d.start      = 1'b0;
         d.st         = SEQ_IDLE;
         d.ch         = CH_REMOTE1;
         d.div        = 11'h000;
         d.tick       = 1'b0;
         d.len        = 7'h00;
         d.meas       = 8'h00;
         d.acc        = 15'h0000;
         d.wait_cnt   = 16'h0000;
         d.conv       = '0;
         d.stat       = 8'h00;
         d.cond       = 8'h00;
         d.fault      = 2'h0;
         d.fault_cond = 2'h0;
         d.alert_n    = 1'b1;
         d.sda_out    = 1'b0;
         d.rd         = q.rd;
      end
   end

   // Gating by ce freezes everything; reset still acts while frozen
   always_ff @(posedge sys_clk) begin
      if (ce || !rstn) begin
         q <= d;
      end
   end

   assign sda_out                   = q.sda_out;
   assign alert_n                   = q.alert_n;
   assign conv_req                  = q.conv;
   assign reading                   = q.rd;
   assign status_bits               = q.stat;
   assign fault_bits                = q.fault;
   assign special_function_register = q.sfr;
   assign configuration_register    = {1'b0, q.cfg};
   assign monitor_running           = q.start;

endmodule : msa_monitor

`default_nettype wire

// >>> tb/msa_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module msa_monitor_asserts
   import msa_pkg::*;
#(
   parameter int CONV_DIV_P   = CONV_DIV,
   parameter int CYCLE_WAIT_P = CYCLE_WAIT_TICKS
)
(
   input wire logic         sys_clk,
   input wire logic         rstn,
   input wire logic         ce,
   input wire logic         sfr_write,
   input wire msa_sfr_type  sfr_wdata,
   input wire logic         cfg_write,
   input wire logic [7:0]   cfg_wdata,
   input wire logic         status_read,
   input wire logic         temp_group_en,
   input wire logic         volt_group_en,
   input wire logic         sda_oe,
   input wire logic         alert_n,
   input wire msa_conv_type conv_req,
   input wire logic [7:0]   status_bits,
   input wire msa_sfr_type  special_function_register,
   input wire logic [7:0]   configuration_register,
   input wire logic         monitor_running
);
   localparam int TLEN = TEMP_CONV_TICKS * CONV_DIV_P;
   localparam int VLEN = VOLT_CONV_TICKS * CONV_DIV_P;
   logic [15:0] gap_q;
   logic [2:0]  prev_ch_q;
   logic        seen_q;
   logic [7:0]  grp_mask;
   int          exp_len;
   logic        soft_rst;
   assign grp_mask = {temp_group_en, {5{volt_group_en}}, {2{temp_group_en}}};
   assign exp_len  = (prev_ch_q inside {CH_REMOTE1, CH_AMBIENT, CH_REMOTE2}) ? TLEN : VLEN;
   assign soft_rst = ce && cfg_write && cfg_wdata[7];

   // Cycles since the previous measurement launch
   always_ff @(posedge sys_clk) begin
      if (!rstn || !monitor_running) begin
         seen_q    <= 1'b0;
         gap_q     <= 16'h0000;
         prev_ch_q <= 3'h0;
      end else if (conv_req.start) begin
         seen_q    <= 1'b1;
         gap_q     <= 16'h0001;
         prev_ch_q <= conv_req.channel;
      end else if (gap_q != 16'hffff) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_first_conv;
      ##1 (conv_req.start && conv_req.channel == CH_REMOTE1);
   endsequence
   sequence s_enable_drop;
      ##[1:16] !special_function_register.global_alert_enable;
   endsequence

   chk_reset_values: assert property (disable iff (1'b0) !rstn |=> alert_n && !sda_oe
      && !conv_req.start && status_bits == 8'h00 && special_function_register == SFR_RESET)
      else $error("reset values wrong");
   chk_soft_reset: assert property (soft_rst |=> special_function_register == SFR_RESET
      && configuration_register == 8'h00 && !monitor_running && status_bits == 8'h00)
      else $error("soft reset incomplete");
   chk_cfg_selfclear: assert property (!configuration_register[7])
      else $error("soft reset bit stuck");
   chk_mode_write: assert property (ce && sfr_write && !cfg_write |=>
      special_function_register.cycle_mode == $past(sfr_wdata.cycle_mode)
      && special_function_register.averaging_select == $past(sfr_wdata.averaging_select))
      else $error("mode or averaging not stored");
   chk_alert_level: assert property ($past(rstn) && !$past(soft_rst) |-> alert_n ==
      !($past(monitor_running) && $past(special_function_register.global_alert_enable)
      && |($past(status_bits) & $past(grp_mask)))) else $error("alert level wrong");
   chk_status_sticky: assert property ($past(rstn) && !$past(status_read) &&
      !$past(soft_rst) |-> ($past(status_bits) & ~status_bits) == 8'h00)
      else $error("status cleared without read");
   chk_ack_clears: assert property ($rose(sda_oe) |-> s_enable_drop)
      else $error("alert enable not cleared after ack");
   chk_launch_first: assert property ($rose(monitor_running) |-> s_first_conv)
      else $error("first conversion missing");
   chk_idle_quiet: assert property (!monitor_running |-> !conv_req.start)
      else $error("conversion while idle");
   chk_conv_len: assert property (conv_req.start && seen_q && prev_ch_q != CH_REMOTE2 |->
      int'(gap_q) >= exp_len - CONV_DIV_P && int'(gap_q) <= exp_len + CONV_DIV_P + 1)
      else $error("conversion length wrong");
   chk_chan_order: assert property (conv_req.start && seen_q |-> conv_req.channel == prev_ch_q
      || conv_req.channel == prev_ch_q + 3'h1) else $error("channel order broken");
endmodule : msa_monitor_asserts

bind msa_monitor msa_monitor_asserts #(.CONV_DIV_P(CONV_DIV_P), .CYCLE_WAIT_P(CYCLE_WAIT_P)) u_chk (
   .sys_clk, .rstn, .ce, .sfr_write, .sfr_wdata, .cfg_write, .cfg_wdata, .status_read,
   .temp_group_en, .volt_group_en, .sda_oe, .alert_n, .conv_req, .status_bits,
   .special_function_register, .configuration_register, .monitor_running);
`default_nettype wire

// >>> tb/msa_smb_host.sv
`timescale 1ns/1ps
`default_nettype none
module msa_smb_host (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_oe
);
   // Clock stands high between frames
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
   end

   task automatic half;
      repeat (4) @(negedge sys_clk);
   endtask : half

   // Sample at end of high phase, device data settles late
   task automatic clk_bit(output logic smp);
      half();
      scl = 1'b1;
      half();
      smp = sda_line;
      scl = 1'b0;
   endtask : clk_bit

   // receive-byte frame to the alert address
   task automatic ara(output logic ack, output logic [7:0] rx);
      logic [7:0] tx;
      logic       dummy;
      tx     = {7'h0c, 1'b1};
      sda_oe = 1'b1;
      half();
      scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         sda_oe = !tx[i];
         clk_bit(dummy);
      end
      sda_oe = 1'b0;
      clk_bit(ack);
      ack = !ack;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(rx[i]);
      end
      // released line gives NACK, then STOP
      clk_bit(dummy);
      sda_oe = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_oe = 1'b0;
      half();
   endtask : ara
endmodule : msa_smb_host
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   n_compared++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module tb
   import msa_pkg::*;
;
   localparam int         DIV  = 4;
   localparam int         WAIT = 50;
   // Arbitrary own address
   localparam logic [6:0] SLV  = 7'h35;
   logic               sys_clk;
   logic               rstn;
   logic               start_write;
   logic               sfr_write;
   logic               cfg_write;
   logic               status_read;
   logic [7:0]         wdata;
   logic [7:0]         event_enable;
   logic [7:0]         conv_data;
   msa_byte_type [7:0] low_limit;
   msa_byte_type [7:0] high_limit;
   logic               scl;
   logic               host_oe;
   logic               sda_oe;
   logic               sda_line;
   logic               sda_out;
   logic               volt_en;
   logic [1:0]         diode_fault;
   logic [1:0]         fault_bits;
   logic               alert_n;
   msa_conv_type       conv_req;
   msa_byte_type [7:0] reading;
   logic [7:0]         status_bits;
   msa_sfr_type        sfr;
   logic [7:0]         cfg;
   logic               running;
   logic               ack;
   logic [7:0]         rx;
   logic [2:0]         last_ch = 3'h0;
   int                 error_cnt = 0;
   int                 n_compared = 0;
   int                 loops = 0;
   int                 cyc = 0;
   int                 last_cyc = 0;
   int                 gap7 = 0;
   int                 cnt_ch [8];

   // Pull-up on the data line
   assign sda_line = !(host_oe || (sda_oe && !sda_out));

   msa_monitor #(.CONV_DIV_P(DIV), .CYCLE_WAIT_P(WAIT)) dut (
      .sys_clk, .rstn, .ce(1'b1), .start_write, .start_wdata(wdata), .sfr_write,
      .sfr_wdata(msa_sfr_type'(wdata)), .cfg_write, .cfg_wdata(wdata), .status_read,
      .event_enable, .temp_group_en(1'b1), .volt_group_en(volt_en), .low_limit, .high_limit,
      .slave_addr(SLV), .conv_data, .diode_fault, .scl_pin(scl), .sda_pin(sda_line),
      .sda_out, .sda_oe, .alert_n, .conv_req, .reading, .status_bits, .fault_bits,
      .special_function_register(sfr), .configuration_register(cfg), .monitor_running(running));

   msa_smb_host host (.sys_clk, .sda_line, .scl, .sda_oe(host_oe));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Sampled mid-cycle, away from the launching edge
   always @(negedge sys_clk) begin
      cyc++;
      if (conv_req.start === 1'b1) begin
         cnt_ch[conv_req.channel]++;
         if (conv_req.channel == 3'h0 && last_ch == 3'h7) begin
            loops++;
            gap7 = cyc - last_cyc;
         end
         last_ch  = conv_req.channel;
         last_cyc = cyc;
      end
   end

   task automatic conclude;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // sel: 0 start, 1 special function, 2 configuration, 3 status read
   task automatic wr(input int sel, input logic [7:0] d);
      @(negedge sys_clk);
      wdata       = d;
      start_write = (sel == 0);
      sfr_write   = (sel == 1);
      cfg_write   = (sel == 2);
      status_read = (sel == 3);
      @(negedge sys_clk);
      {start_write, sfr_write, cfg_write, status_read} = 4'h0;
      @(negedge sys_clk);
   endtask : wr

   task automatic wait_loop;
      int l0;
      int n;
      l0 = loops;
      n  = 0;
      while (loops == l0 && n < 30000) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(loops, l0 + 1)
   endtask : wait_loop

   initial begin
      repeat (80000) @(posedge sys_clk);
      error_cnt++;
      conclude();
   end

   initial begin
      rstn = 1'b0;
      {start_write, sfr_write, cfg_write, status_read} = 4'h0;
      wdata        = 8'h00;
      conv_data    = 8'h50;
      event_enable = 8'hff;
      volt_en      = 1'b1;
      diode_fault  = 2'h0;
      foreach (cnt_ch[i]) cnt_ch[i] = 0;
      // Temperatures signed, voltages unsigned; supply high limit equals the sample
      for (int i = 0; i < 8; i++) begin
         low_limit[i]  = (i == 0 || i == 1 || i == 7) ? 8'h80 : 8'h00;
         high_limit[i] = (i == 0 || i == 1 || i == 7) ? 8'h7f : 8'hff;
      end
      high_limit[2] = 8'h50;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (50) @(negedge sys_clk);
      `CHK(sfr, SFR_RESET)
      `CHK({cfg, status_bits, alert_n, running}, {8'h00, 8'h00, 1'b1, 1'b0})
      `CHK(cnt_ch[0], 0)
      wr(1, 8'h44);
      `CHK(sfr, msa_sfr_type'(8'h44))
      wr(2, 8'h80);
      `CHK({sfr, cfg}, {SFR_RESET, 8'h00})
      wr(1, 8'h24);
      wr(0, 8'h01);
      wait_loop();
      for (int i = 1; i < 8; i++) `CHK(cnt_ch[i], (i == 7) ? 16 : 1)
      `CHK(reading, {8{8'h50}})
      `CHK({status_bits, alert_n}, {8'h04, 1'b0})
      `CHK(gap7 <= DIV * TEMP_CONV_TICKS + DIV + 1, 1'b1)
      host.ara(ack, rx);
      `CHK({ack, rx[7:1]}, {1'b1, SLV})
      `CHK({sfr.global_alert_enable, alert_n}, 2'b01)
      host.ara(ack, rx);
      `CHK(ack, 1'b0)
      wr(3, 8'h00);
      `CHK(status_bits, 8'h04)
      volt_en = 1'b0;
      wr(1, 8'h24);
      host.ara(ack, rx);
      `CHK({ack, alert_n, sfr.global_alert_enable}, 3'b011)
      volt_en = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(alert_n, 1'b0)
      high_limit[2] = 8'hff;
      wait_loop();
      wr(3, 8'h00);
      `CHK({status_bits, alert_n}, {8'h00, 1'b1})
      wr(1, 8'h26);
      diode_fault = 2'b10;
      wait_loop();
      `CHK(gap7 >= DIV * (TEMP_CONV_TICKS + WAIT) - DIV, 1'b1)
      `CHK({fault_bits, status_bits, reading[7]}, {2'b10, 8'h80, FAULT_READING})
      conclude();
   end
endmodule : tb
`default_nettype wire
